// File: sdrct_defines.svh
// Purpose: constants for the synchronous DRAM command/timing block
// Assumes: 100 MHz clock, 10 ns period
// Notes: definitions only
`ifndef SDRCT_DEFINES_SVH
`define SDRCT_DEFINES_SVH
`define SDRCT_CLK_PERIOD_NS 10
`define SDRCT_BL_LSB 0
`define SDRCT_BL_MSB 2
`define SDRCT_BT_BIT 3
`define SDRCT_RL_LSB 4
`define SDRCT_RL_MSB 6
`define SDRCT_WBM_BIT 9
`define SDRCT_MODE_RESET 12'h020
`define SDRCT_MASK_READ_LAT 2
`define SDRCT_MASK_WRITE_LAT 0
`define SDRCT_ROW_W 12
`define SDRCT_COL_W 8
`define SDRCT_BANKS 4
`define SDRCT_MEM_DEPTH 256
`endif

// File: sdrct_pkg.sv
// Purpose: types for the synchronous DRAM command/timing block
// Assumes: nothing
// Notes: command codes are {select_n, row_n, column_n, write_n}
package sdrct_pkg;
   typedef enum logic [3:0] {
      SDRCT_CMD_INHIBIT = 4'h8,
      SDRCT_CMD_MODE = 4'h0,
      SDRCT_CMD_REFRESH = 4'h1,
      SDRCT_CMD_PRECHARGE = 4'h2,
      SDRCT_CMD_ACTIVE = 4'h3,
      SDRCT_CMD_WRITE = 4'h4,
      SDRCT_CMD_READ = 4'h5,
      SDRCT_CMD_STOP = 4'h6,
      SDRCT_CMD_NOP = 4'h7
   } sdrct_cmd_t;
   typedef enum logic [1:0] {
      SDRCT_ST_IDLE = 2'b00,
      SDRCT_ST_READ = 2'b01,
      SDRCT_ST_WRITE = 2'b10
   } sdrct_state_t;
endpackage

// File: sdrct_store.sv
// Purpose: data store, one 16-bit word per column with per-byte write
// Assumes: bank/row selection is folded out; columns index storage
// Notes: flip-flop storage, write mask has zero latency
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_defines.svh"
module sdrct_store (
   input wire logic clock, // Device clock
   input wire logic rst_n, // Synchronised reset, active low
   input wire logic enable, // Internal clock enable
   input wire logic write_en, // Write this cycle
   input wire logic [1:0] byte_mask, // High suppresses the lane
   input wire logic [`SDRCT_COL_W-1:0] addr, // Column index
   input wire logic [15:0] wdata, // Write word
   output logic [15:0] rdata // Combinational read word
);
   logic [15:0] mem [`SDRCT_MEM_DEPTH];
   genvar g;
   generate
      for (g = 0; g < `SDRCT_MEM_DEPTH; g++) begin : g_word
         logic [15:0] next_word;
         always_comb begin
            next_word = mem[g];
            if (enable && write_en && int'(addr) == g) begin
               if (!byte_mask[0]) next_word[7:0] = wdata[7:0];
               if (!byte_mask[1]) next_word[15:8] = wdata[15:8];
            end
         end
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) mem[g] <= 16'h0000;
            else mem[g] <= next_word;
         end
      end
   endgenerate
   assign rdata = mem[addr];
endmodule // sdrct_store
`default_nettype wire

// File: sdrct_core.sv
// Purpose: command decode, mode register, burst and data timing of a
//   four-bank synchronous DRAM with a 16-bit data path
// Assumes: controller keeps its own spacing; inputs are same-clock logic
// Notes: one row buffer per bank is not modelled; data keyed by column
// Contract
// - Read mask floats the matching lane two cycles later.
// - Write mask blocks the lane sampled the same cycle.
// - First write word is taken with the WRITE command.
// - PRECHARGE stops read data after latency cycles.
// - Clock enable low suspends the device one cycle later.
// - Clock enable high resumes the device one cycle later.
// - ACTIVE takes bank bits as bank and twelve lines as row.
// - READ or WRITE takes eight low lines as start column.
// - Mode bits: burst length low three, read latency above type bit.
// - READ at edge n with latency m of two or more gives data by edge n plus m.
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_defines.svh"
module sdrct_core (
   input wire logic clock, // Device clock, 100 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic clock_enable, // High lets the device advance
   input wire logic select_n, // Chip select, active low
   input wire logic row_strobe_n, // Row strobe, active low
   input wire logic column_strobe_n, // Column strobe, active low
   input wire logic write_enable_n, // Write enable, active low
   input wire logic bank_select_bit0, // Bank select low bit
   input wire logic bank_select_bit1, // Bank select high bit
   input wire logic [11:0] row_column_address, // Row, column or mode
   input wire logic [1:0] byte_mask, // Per-lane mask, high masks
   input wire logic [15:0] data_in, // Data lines, inbound
   output logic [15:0] data_out, // Data lines, outbound
   output logic [1:0] data_oe, // Per-lane drive enable
   output logic [11:0] mode_word, // Loaded mode register
   output logic [3:0] bank_open, // Bank has an open row
   output logic [`SDRCT_ROW_W-1:0] open_row, // Row of last ACTIVE
   output logic [1:0] active_bank, // Bank of last ACTIVE
   output logic suspended // Device is frozen
);
   logic rst_meta, rst_sync;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Enable acts one cycle late, so the command on the lowering edge
   // still executes.
   logic en_q, next_en_q;
   always_comb next_en_q = clock_enable;
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) en_q <= 1'b1;
      else en_q <= next_en_q;
   end
   logic run;
   assign run = en_q;

   sdrct_pkg::sdrct_cmd_t cmd;
   assign cmd = sdrct_pkg::sdrct_cmd_t'({select_n, row_strobe_n,
      column_strobe_n, write_enable_n});
   logic [1:0] bank_in;
   assign bank_in = {bank_select_bit1, bank_select_bit0};

   sdrct_pkg::sdrct_state_t state, next_state;
   logic [11:0] next_mode;
   logic [3:0] next_bank_open;
   logic [`SDRCT_ROW_W-1:0] next_row;
   logic [1:0] next_abank;
   logic [`SDRCT_COL_W-1:0] col, next_col;
   logic [8:0] left, next_left;
   logic [2:0] lat_cnt, next_lat_cnt;
   logic [2:0] stop_cnt, next_stop_cnt;
   logic wr_now;
   logic [`SDRCT_COL_W-1:0] wr_addr;
   logic [15:0] rd_word;
   logic [8:0] burst_len;
   logic [2:0] rlat;

   always_comb begin
      case (mode_word[`SDRCT_BL_MSB:`SDRCT_BL_LSB])
         3'h0: burst_len = 9'h001;
         3'h1: burst_len = 9'h002;
         3'h2: burst_len = 9'h004;
         3'h3: burst_len = 9'h008;
         3'h7: burst_len = 9'h100;
         default: burst_len = 9'h001;
      endcase
      rlat = mode_word[`SDRCT_RL_MSB:`SDRCT_RL_LSB];
   end

   // Next column wraps inside the burst block of the programmed length
   function automatic logic [`SDRCT_COL_W-1:0] step_col(
      input logic [`SDRCT_COL_W-1:0] c, input logic [8:0] bl,
      input logic interleave);
      logic [`SDRCT_COL_W-1:0] m;
      logic [`SDRCT_COL_W-1:0] s;
      m = 8'(bl - 9'h001);
      s = interleave ? 8'h00 : 8'(c + 8'h01);
      step_col = (c & ~m) | (s & m);
   endfunction

   always_comb begin
      next_state = state;
      next_mode = mode_word;
      next_bank_open = bank_open;
      next_row = open_row;
      next_abank = active_bank;
      next_col = col;
      next_left = left;
      next_lat_cnt = lat_cnt;
      next_stop_cnt = stop_cnt;
      wr_now = 1'b0;
      wr_addr = col;
      if (run) begin
         // Counters hold while suspended, like the rest of the state
         next_lat_cnt = (lat_cnt != 3'h0) ? 3'(lat_cnt - 3'h1) : 3'h0;
         next_stop_cnt = (stop_cnt != 3'h0) ? 3'(stop_cnt - 3'h1) : 3'h0;
         // Burst progress
         case (state)
            sdrct_pkg::SDRCT_ST_WRITE: begin
               wr_now = 1'b1;
               next_col = step_col(col, burst_len,
                  mode_word[`SDRCT_BT_BIT]);
               next_left = 9'(left - 9'h001);
               if (left == 9'h001) next_state = sdrct_pkg::SDRCT_ST_IDLE;
            end
            sdrct_pkg::SDRCT_ST_READ: begin
               if (lat_cnt <= 3'h2) begin
                  next_col = step_col(col, burst_len,
                     mode_word[`SDRCT_BT_BIT]);
                  next_left = 9'(left - 9'h001);
                  if (left == 9'h001) next_state = sdrct_pkg::SDRCT_ST_IDLE;
               end
            end
            sdrct_pkg::SDRCT_ST_IDLE: ;
            default: next_state = sdrct_pkg::SDRCT_ST_IDLE;
         endcase
         if (stop_cnt == 3'h2) next_state = sdrct_pkg::SDRCT_ST_IDLE;
         case (cmd)
            sdrct_pkg::SDRCT_CMD_MODE: next_mode = row_column_address;
            sdrct_pkg::SDRCT_CMD_ACTIVE: begin
               next_bank_open[bank_in] = 1'b1;
               next_row = row_column_address;
               next_abank = bank_in;
            end
            sdrct_pkg::SDRCT_CMD_PRECHARGE: begin
               if (row_column_address[10]) next_bank_open = 4'h0;
               else next_bank_open[bank_in] = 1'b0;
               if (state == sdrct_pkg::SDRCT_ST_READ)
                  next_stop_cnt = rlat;
               else next_state = sdrct_pkg::SDRCT_ST_IDLE;
            end
            sdrct_pkg::SDRCT_CMD_STOP: begin
               // Data on the stop edge is not written
               wr_now = 1'b0;
               if (state == sdrct_pkg::SDRCT_ST_READ) next_stop_cnt = rlat;
               else next_state = sdrct_pkg::SDRCT_ST_IDLE;
            end
            sdrct_pkg::SDRCT_CMD_WRITE: begin
               // First word lands with the command itself
               wr_now = 1'b1;
               wr_addr = row_column_address[`SDRCT_COL_W-1:0];
               next_stop_cnt = 3'h0;
               next_col = step_col(wr_addr, burst_len,
                  mode_word[`SDRCT_BT_BIT]);
               if (mode_word[`SDRCT_WBM_BIT] || burst_len == 9'h001)
                  next_state = sdrct_pkg::SDRCT_ST_IDLE;
               else begin
                  next_left = 9'(burst_len - 9'h001);
                  next_state = sdrct_pkg::SDRCT_ST_WRITE;
               end
            end
            sdrct_pkg::SDRCT_CMD_READ: begin
               next_col = row_column_address[`SDRCT_COL_W-1:0];
               next_left = burst_len;
               next_lat_cnt = rlat;
               next_stop_cnt = 3'h0;
               next_state = sdrct_pkg::SDRCT_ST_READ;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= sdrct_pkg::SDRCT_ST_IDLE;
         mode_word <= `SDRCT_MODE_RESET;
         bank_open <= 4'h0;
         open_row <= 12'h000;
         active_bank <= 2'h0;
         col <= 8'h00;
         left <= 9'h000;
         lat_cnt <= 3'h0;
         stop_cnt <= 3'h0;
      end else begin
         state <= next_state;
         mode_word <= next_mode;
         bank_open <= next_bank_open;
         open_row <= next_row;
         active_bank <= next_abank;
         col <= next_col;
         left <= next_left;
         lat_cnt <= next_lat_cnt;
         stop_cnt <= next_stop_cnt;
      end
   end

   sdrct_store u_store (
      .clock(clock),
      .rst_n(rst_sync),
      .enable(run),
      .write_en(wr_now),
      .byte_mask(byte_mask),
      .addr(wr_addr),
      .wdata(data_in),
      .rdata(rd_word)
   );

   // Read mask delay line; masks then float lanes two cycles on
   logic [1:0] mask_d1, mask_d2, next_mask_d1, next_mask_d2;
   logic [15:0] next_dout;
   logic [1:0] next_oe;
   logic out_valid;
   // Outputs register one edge early so a word is valid at edge n + m for m of two or more;
   // a cut burst drops its drive one edge before the latency runs out
   assign out_valid = state == sdrct_pkg::SDRCT_ST_READ &&
      lat_cnt <= 3'h2 && stop_cnt != 3'h2;
   always_comb begin
      next_mask_d1 = mask_d1;
      next_mask_d2 = mask_d2;
      next_dout = data_out;
      next_oe = data_oe;
      if (run) begin
         next_mask_d1 = byte_mask;
         next_mask_d2 = mask_d1;
         next_dout = rd_word;
         next_oe = out_valid ? ~next_mask_d2 : 2'b00;
      end
   end
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         mask_d1 <= 2'b11;
         mask_d2 <= 2'b11;
         data_out <= 16'h0000;
         data_oe <= 2'b00;
         suspended <= 1'b0;
      end else begin
         mask_d1 <= next_mask_d1;
         mask_d2 <= next_mask_d2;
         data_out <= next_dout;
         data_oe <= next_oe;
         suspended <= ~next_en_q;
      end
   end
endmodule // sdrct_core
`default_nettype wire

// File: sdrct_ctrl_model.sv
// Purpose: memory controller model driving the command side
// Assumes: 100 MHz clock; minimum spacings rounded up to whole cycles
// Notes: power-up wait shortened; released data lines toggle each cycle
`timescale 1ns/1ps
`default_nettype none
module sdrct_ctrl_model #(
   parameter int T_INIT = 10 // Power-up wait in cycles, shortened
) (
   input wire logic clock, // Device clock
   output logic clock_enable, // Clock enable
   output logic [3:0] cmd, // {select_n, row, column, write} strobes
   output logic [1:0] bank, // Bank select
   output logic [11:0] addr, // Address lines
   output logic [1:0] byte_mask, // Lane masks, high masks
   output logic [15:0] data_in // Write data
);
   localparam int T_RC = 7;
   localparam int T_RP = 2;
   localparam int T_RCD = 2;
   initial begin
      clock_enable = 1'b1;
      cmd = sdrct_pkg::SDRCT_CMD_INHIBIT;
      bank = 2'h0;
      addr = 12'h000;
      byte_mask = 2'h3;
      data_in = 16'h0000;
   end
   task automatic put(input logic [3:0] c, input logic [1:0] b,
         input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
      @(negedge clock);
      cmd = c;
      bank = b;
      addr = a;
      byte_mask = m;
      data_in = d;
   endtask
   task automatic nop(input int n);
      repeat (n) put(sdrct_pkg::SDRCT_CMD_NOP, bank, addr, 2'h0, ~data_in);
   endtask
   task automatic pre_all();
      put(sdrct_pkg::SDRCT_CMD_PRECHARGE, 2'h0, 12'h400, 2'h0, ~data_in);
      nop(T_RP);
   endtask
   task automatic load(input logic [11:0] mode);
      put(sdrct_pkg::SDRCT_CMD_MODE, 2'h0, mode, 2'h0, ~data_in);
      nop(2);
   endtask
   task automatic init(input logic [11:0] mode);
      repeat (T_INIT) put(cmd, 2'h0, 12'h000, 2'h3, data_in);
      pre_all();
      repeat (2) begin
         // A run is far shorter than one refresh period
         put(sdrct_pkg::SDRCT_CMD_REFRESH, 2'h0, 12'h000, 2'h0,
            ~data_in);
         nop(T_RC);
      end
      load(mode);
   endtask
   task automatic activate(input logic [1:0] b, input logic [11:0] row);
      put(sdrct_pkg::SDRCT_CMD_ACTIVE, b, row, 2'h0, ~data_in);
      nop(T_RCD);
   endtask
   // Lowers clock enable for n - 1 rising edges, command lines left as last driven
   task automatic suspend(input int n);
      @(negedge clock);
      clock_enable = 1'b0;
      repeat (n - 1) @(negedge clock);
      clock_enable = 1'b1;
   endtask
endmodule // sdrct_ctrl_model
`default_nettype wire

// File: sdrct_core_chk.sv
// Purpose: port-level checks of the DRAM command/timing core
// Assumes: a command counts only if clock enable was high an edge before
// Notes: checks wait three edges for the internal reset copy to clear
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_defines.svh"
module sdrct_core_chk (
   input wire logic clock, // Device clock
   input wire logic rst_n, // Reset, active low
   input wire logic clock_enable, // Clock enable
   input wire logic select_n, // Command bit
   input wire logic row_strobe_n, // Command bit
   input wire logic column_strobe_n, // Command bit
   input wire logic write_enable_n, // Command bit
   input wire logic bank_select_bit0, // Bank low bit
   input wire logic bank_select_bit1, // Bank high bit
   input wire logic [11:0] row_column_address, // Address lines
   input wire logic [1:0] byte_mask, // Lane masks
   input wire logic [15:0] data_out, // Read data
   input wire logic [1:0] data_oe, // Lane drive
   input wire logic [11:0] mode_word, // Mode register
   input wire logic [`SDRCT_ROW_W-1:0] open_row, // Row of last ACTIVE
   input wire logic [1:0] active_bank, // Bank of last ACTIVE
   input wire logic suspended // Frozen flag
);
   logic [3:0] cmd;
   logic [1:0] age;
   logic ce_q;
   logic ok;
   logic go;
   assign cmd = {select_n, row_strobe_n, column_strobe_n, write_enable_n};
   assign ok = age == 2'h3;
   assign go = ok && ce_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         age <= 2'h0;
         ce_q <= 1'b0;
      end else begin
         age <= age + {1'b0, !ok};
         ce_q <= clock_enable;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_act;
      go && cmd == sdrct_pkg::SDRCT_CMD_ACTIVE |=> open_row ==
         $past(row_column_address) && active_bank ==
         $past({bank_select_bit1, bank_select_bit0});
   endproperty
   a_act: assert property (p_act) else $error("row or bank lost");
   property p_mode;
      go && cmd == sdrct_pkg::SDRCT_CMD_MODE |=>
         mode_word == $past(row_column_address);
   endproperty
   a_mode: assert property (p_mode) else $error("mode not loaded");
   property p_cl2;
      go && clock_enable && cmd == sdrct_pkg::SDRCT_CMD_READ &&
         mode_word[6:4] == 3'h2 && byte_mask == 2'h0 ##1 clock_enable
         |=> data_oe == 2'h3;
   endproperty
   a_cl2: assert property (p_cl2) else $error("late data, two");
   property p_cl3;
      go && clock_enable && cmd == sdrct_pkg::SDRCT_CMD_READ &&
         mode_word[6:4] == 3'h3 && byte_mask == 2'h0 ##1
         clock_enable [*2] |=> data_oe == 2'h3;
   endproperty
   a_cl3: assert property (p_cl3) else $error("late data, three");
   property p_mask;
      go && clock_enable ##1 clock_enable |=>
         (data_oe & $past(byte_mask, 2)) == 2'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked lane driven");
   property p_pre;
      go && clock_enable && cmd == sdrct_pkg::SDRCT_CMD_READ &&
         mode_word[6:4] == 3'h3 ##1 clock_enable &&
         cmd == sdrct_pkg::SDRCT_CMD_PRECHARGE ##1 clock_enable [*2]
         |=> data_oe == 2'h0;
   endproperty
   a_pre: assert property (p_pre) else $error("drive after stop");
   property p_susp;
      ok && !clock_enable |=> suspended;
   endproperty
   a_susp: assert property (p_susp) else $error("no suspend");
   property p_run;
      ok && clock_enable |=> !suspended;
   endproperty
   a_run: assert property (p_run) else $error("no resume");
   property p_frz;
      ok && !clock_enable |-> ##2 $stable(data_out) && $stable(data_oe);
   endproperty
   a_frz: assert property (p_frz) else $error("moved while frozen");
   c_wr: cover property (go && cmd == sdrct_pkg::SDRCT_CMD_WRITE);
   c_rd: cover property (go && cmd == sdrct_pkg::SDRCT_CMD_READ);
   c_susp: cover property (suspended [*2]);
endmodule // sdrct_core_chk
bind sdrct_core sdrct_core_chk chk_u (.clock(clock), .rst_n(rst_n),
   .clock_enable(clock_enable), .select_n(select_n),
   .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
   .write_enable_n(write_enable_n), .bank_select_bit0(bank_select_bit0),
   .bank_select_bit1(bank_select_bit1), .byte_mask(byte_mask),
   .row_column_address(row_column_address), .data_out(data_out),
   .data_oe(data_oe), .mode_word(mode_word), .open_row(open_row),
   .active_bank(active_bank), .suspended(suspended));
`default_nettype wire

// File: test_sdrct_core.sv
// Purpose: self-checking bench for the DRAM command/timing core
// Assumes: the controller model keeps every spacing rule
// Notes: storage ignores bank and row; banks only move the bank flags
`timescale 1ns/1ps
`default_nettype none
`include "sdrct_defines.svh"
module test_sdrct_core;
   logic clock;
   logic rst_n;
   logic clock_enable;
   logic [3:0] cmd;
   logic [1:0] bank;
   logic [11:0] addr;
   logic [1:0] byte_mask;
   logic [15:0] data_in;
   logic [15:0] data_out;
   logic [1:0] data_oe;
   logic [11:0] mode_word;
   logic [`SDRCT_ROW_W-1:0] open_row;
   logic [1:0] active_bank;
   logic [3:0] bank_open;
   logic suspended;
   int fails;
   int checks_done;
   // Second write masks lane 0 of word 1 and lane 1 of word 2
   localparam logic [63:0] STORED = 64'h2023_1022_2011_2020;
   sdrct_ctrl_model ctrl_u (.clock(clock), .clock_enable(clock_enable),
      .cmd(cmd), .bank(bank), .addr(addr), .byte_mask(byte_mask),
      .data_in(data_in));
   sdrct_core dut_u (.clock(clock), .rst_n(rst_n),
      .clock_enable(clock_enable), .select_n(cmd[3]),
      .row_strobe_n(cmd[2]), .column_strobe_n(cmd[1]),
      .write_enable_n(cmd[0]), .bank_select_bit0(bank[0]),
      .bank_select_bit1(bank[1]), .row_column_address(addr),
      .byte_mask(byte_mask), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .mode_word(mode_word), .bank_open(bank_open),
      .open_row(open_row), .active_bank(active_bank),
      .suspended(suspended));
   initial clock = 1'b0;
   always #5 clock = ~clock;
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("wrong value at %0t: %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] b, input logic [7:0] col,
         input logic [15:0] base, input logic [7:0] mk);
      // Bit 10 stays low: no auto precharge, so its long gap never applies
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_WRITE, b, {4'h0, col}, mk[1:0],
         base);
      for (int i = 1; i < 4; i++) begin
         ctrl_u.put(sdrct_pkg::SDRCT_CMD_NOP, b, {4'h0, col}, mk[2*i+:2],
            base + 16'(i));
      end
      ctrl_u.nop(2);
   endtask
   // Burst of four from column col; the mask rides on the READ cycle
   task automatic rd(input int lat, input logic [1:0] b,
         input logic [7:0] col, input logic [1:0] mk,
         input logic [63:0] exp);
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_READ, b, {4'h0, col}, mk, ~data_in);
      ctrl_u.nop(lat);
      for (int i = 0; i < 4; i++) begin
         check(16'(data_oe), i == 0 ? {14'h0, ~mk} : 16'h0003);
         if (i > 0 || mk == 2'h0) check(data_out, exp[16*i+:16]);
         ctrl_u.nop(1);
      end
      check(16'(data_oe), 16'h0000);
   endtask
   initial begin
      #12000; // Roughly ten times the expected run
      fails++;
      print_verdict();
   end
   initial begin
      fails = 0;
      checks_done = 0;
      rst_n = 1'b0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      ctrl_u.init(12'h022);
      check(16'(mode_word), 16'h0022);
      ctrl_u.activate(2'h2, 12'habc);
      check(16'(open_row), 16'h0abc);
      check(16'(active_bank), 16'h0002);
      check(16'(bank_open), 16'h0004);
      wr(2'h2, 8'h10, 16'h1010, 8'h00);
      wr(2'h2, 8'h10, 16'h2020, 8'h24);
      rd(2, 2'h2, 8'h10, 2'h0, STORED);
      rd(2, 2'h2, 8'h10, 2'h2, STORED);
      ctrl_u.pre_all();
      ctrl_u.load(12'h032);
      ctrl_u.activate(2'h2, 12'h5a5);
      rd(3, 2'h2, 8'h10, 2'h0, STORED);
      // Precharge on the edge after the read cuts the burst short
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_READ, 2'h2, 12'h010, 2'h0, ~data_in);
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_PRECHARGE, 2'h2, 12'h000, 2'h0,
         ~data_in);
      ctrl_u.nop(2);
      check(16'(data_oe), 16'h0003);
      ctrl_u.nop(1);
      check(16'(data_oe), 16'h0000);
      ctrl_u.activate(2'h1, 12'h3c3);
      check(16'(open_row), 16'h03c3);
      check(16'(active_bank), 16'h0001);
      check(16'(bank_open), 16'h0002);
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_READ, 2'h1, 12'h010, 2'h0, ~data_in);
      ctrl_u.nop(3);
      check(data_out, 16'h2020);
      ctrl_u.suspend(3);
      check(16'(suspended), 16'h0001);
      check(data_out, 16'h1022);
      ctrl_u.nop(1);
      check(16'(suspended), 16'h0000);
      check(data_out, 16'h1022);
      ctrl_u.nop(1);
      check(data_out, 16'h2023);
      // Stop after the second word leaves the rest of the block untouched
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_WRITE, 2'h1, 12'h020, 2'h0,
         16'h3030);
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_NOP, 2'h1, 12'h020, 2'h0, 16'h3031);
      ctrl_u.put(sdrct_pkg::SDRCT_CMD_STOP, 2'h1, 12'h020, 2'h0,
         16'h3032);
      ctrl_u.nop(1);
      rd(3, 2'h1, 8'h20, 2'h0, 64'h0000_0000_3031_3030);
      ctrl_u.nop(4);
      print_verdict();
   end
endmodule // test_sdrct_core
`default_nettype wire
